/* File: rtl/gpe_ports.v */
`timescale 1ns/10ps
`include "gpe_map.vh"
module gpe_ports
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // port e pins and peripheral overrides
  input  wire [7:0]  pe_pin_i,
  output reg  [7:0]  pe_out_o,
  output reg  [7:0]  pe_oe_o,
  input  wire [7:0]  pe_periph_own_i,
  input  wire [7:0]  pe_periph_out_i,
  input  wire [7:0]  pe_periph_oe_i,
  // port f pins and timer channels
  input  wire [6:0]  pf_pin_i,
  output reg  [6:0]  pf_out_o,
  output reg  [6:0]  pf_oe_o,
  input  wire [11:0] edge_level_select_pair_i,
  input  wire [5:0]  timer_channel_out_i,
  input  wire [5:0]  timer_channel_oe_i,
  // port g/h pins and keyboard enables
  input  wire [2:0]  pg_pin_i,
  output reg  [2:0]  pg_out_o,
  output reg  [2:0]  pg_oe_o,
  input  wire [1:0]  ph_pin_i,
  output reg  [1:0]  ph_out_o,
  output reg  [1:0]  ph_oe_o,
  input  wire [4:0]  keyboard_irq_enable_i
);

  reg  [7:0]  port_e_data_r;
  reg  [6:0]  port_f_data_r;
  reg  [2:0]  port_g_data_r;
  reg  [1:0]  port_h_data_r;
  reg  [7:0]  port_e_direction_r;
  reg  [6:0]  port_f_direction_r;
  reg  [2:0]  port_g_direction_r;
  reg  [1:0]  port_h_direction_r;
  reg  [19:0] pin_s1_r;
  reg  [19:0] pin_s2_r;
  reg         wr_pend_r;
  reg  [11:0] wr_addr_r;
  reg  [31:0] rd_nxt;
  reg  [7:0]  pe_out_nxt;
  reg  [7:0]  pe_oe_nxt;
  reg  [6:0]  pf_out_nxt;
  reg  [6:0]  pf_oe_nxt;
  reg  [2:0]  pg_oe_nxt;
  reg  [1:0]  ph_oe_nxt;
  wire [7:0]  pe_sync;
  wire [6:0]  pf_sync;
  wire [2:0]  pg_sync;
  wire [1:0]  ph_sync;
  wire [5:0]  timer_own;
  wire        acc;
  wire [11:0] word_addr;
  wire        dir_we_e;
  wire        dir_we_f;
  wire        dir_we_g;
  wire        dir_we_h;
  wire        dat_we_e;
  wire        dat_we_f;
  wire        dat_we_g;
  wire        dat_we_h;

  // pins are asynchronous to the bus clock
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_s1_r <= 20'h0_0000;
      pin_s2_r <= 20'h0_0000;
    end
    else
    begin
      pin_s1_r <= {ph_pin_i, pg_pin_i, pf_pin_i, pe_pin_i};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign pe_sync = pin_s2_r[7:0];
  assign pf_sync = pin_s2_r[14:8];
  assign pg_sync = pin_s2_r[17:15];
  assign ph_sync = pin_s2_r[19:18];

  // a channel is live when its edge/level pair is nonzero
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_tmr
      assign timer_own[gi] = |edge_level_select_pair_i[2*gi+1:2*gi];
    end
  endgenerate

  assign acc       = hsel_i & hready_i & htrans_i[`GPE_HTRANS_NS];
  // registers are word-spaced: byte address is index times four
  assign word_addr = haddr_i[13:2];

  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (word_addr)
      `GPE_OFS_E_DATA: rd_nxt[7:0] = (port_e_direction_r & port_e_data_r) | (~port_e_direction_r & pe_sync);
      `GPE_OFS_F_DATA: rd_nxt[6:0] = (port_f_direction_r & port_f_data_r) | (~port_f_direction_r & pf_sync);
      `GPE_OFS_G_DATA: rd_nxt[2:0] = (port_g_direction_r & port_g_data_r) | (~port_g_direction_r & pg_sync);
      `GPE_OFS_H_DATA: rd_nxt[1:0] = (port_h_direction_r & port_h_data_r) | (~port_h_direction_r & ph_sync);
      `GPE_IDX_E_DIR:  rd_nxt[7:0] = port_e_direction_r;
      `GPE_IDX_F_DIR:  rd_nxt[6:0] = port_f_direction_r;
      `GPE_IDX_G_DIR:  rd_nxt[2:0] = port_g_direction_r;
      `GPE_IDX_H_DIR:  rd_nxt[1:0] = port_h_direction_r;
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  // write strobes come from the address held over into the data phase
  assign dir_we_e = wr_pend_r & (wr_addr_r == `GPE_IDX_E_DIR);
  assign dir_we_f = wr_pend_r & (wr_addr_r == `GPE_IDX_F_DIR);
  assign dir_we_g = wr_pend_r & (wr_addr_r == `GPE_IDX_G_DIR);
  assign dir_we_h = wr_pend_r & (wr_addr_r == `GPE_IDX_H_DIR);
  assign dat_we_e = wr_pend_r & (wr_addr_r == `GPE_OFS_E_DATA);
  assign dat_we_f = wr_pend_r & (wr_addr_r == `GPE_OFS_F_DATA);
  assign dat_we_g = wr_pend_r & (wr_addr_r == `GPE_OFS_G_DATA);
  assign dat_we_h = wr_pend_r & (wr_addr_r == `GPE_OFS_H_DATA);

  // bus slave: zero wait states, always okay
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_pend_r <= 1'b0;
    end
    else
    begin
      wr_pend_r <= acc & hwrite_i;
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_addr_r <= 12'h000;
    end
    else
    begin
      if (acc)
      begin
        wr_addr_r <= word_addr;
      end
    end
  end

  // read data registered so it stands in the data phase
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hrdata_o <= 32'h0000_0000;
    end
    else
    begin
      if (acc & ~hwrite_i)
      begin
        hrdata_o <= rd_nxt;
      end
    end
  end

  // every register answers at once, so no wait state is ever needed
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hreadyout_o <= 1'b1;
    end
    else
    begin
      hreadyout_o <= 1'b1;
    end
  end

  // unmapped accesses are harmless, so errors are never signalled
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hresp_o <= 1'b0;
    end
    else
    begin
      hresp_o <= 1'b0;
    end
  end

  // direction bits reset to input; data latches have no reset
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      port_e_direction_r <= `GPE_DIR_RST;
    end
    else
    begin
      if (dir_we_e)
      begin
        port_e_direction_r <= hwdata_i[7:0];
      end
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      port_f_direction_r <= `GPE_DIR_RST_F;
    end
    else
    begin
      if (dir_we_f)
      begin
        port_f_direction_r <= hwdata_i[6:0];
      end
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      port_g_direction_r <= `GPE_DIR_RST_G;
    end
    else
    begin
      if (dir_we_g)
      begin
        port_g_direction_r <= hwdata_i[2:0];
      end
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      port_h_direction_r <= `GPE_DIR_RST_H;
    end
    else
    begin
      if (dir_we_h)
      begin
        port_h_direction_r <= hwdata_i[1:0];
      end
    end
  end

  // latches untouched by reset, so power-up content is unknown until written
  always @(posedge clk_i)
  begin
    if (dat_we_e)
    begin
      port_e_data_r <= hwdata_i[7:0];
    end
  end

  always @(posedge clk_i)
  begin
    if (dat_we_f)
    begin
      port_f_data_r <= hwdata_i[6:0];
    end
  end

  always @(posedge clk_i)
  begin
    if (dat_we_g)
    begin
      port_g_data_r <= hwdata_i[2:0];
    end
  end

  always @(posedge clk_i)
  begin
    if (dat_we_h)
    begin
      port_h_data_r <= hwdata_i[1:0];
    end
  end

  always @*
  begin
    pe_out_nxt = (pe_periph_own_i & pe_periph_out_i) | (~pe_periph_own_i & port_e_data_r);
    pe_oe_nxt  = (pe_periph_own_i & pe_periph_oe_i) | (~pe_periph_own_i & port_e_direction_r);
    pf_out_nxt = port_f_data_r;
    pf_oe_nxt  = port_f_direction_r;
    pf_out_nxt[5:0] = (timer_own & timer_channel_out_i) | (~timer_own & port_f_data_r[5:0]);
    pf_oe_nxt[5:0]  = (timer_own & timer_channel_oe_i) | (~timer_own & port_f_direction_r[5:0]);
    pg_oe_nxt  = ~keyboard_irq_enable_i[2:0] & port_g_direction_r;
    ph_oe_nxt  = ~keyboard_irq_enable_i[4:3] & port_h_direction_r;
  end

  // output enables reset low so no pin drives before software asks
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pe_out_o <= 8'h00;
      pe_oe_o  <= 8'h00;
    end
    else
    begin
      pe_out_o <= pe_out_nxt;
      pe_oe_o  <= pe_oe_nxt;
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pf_out_o <= 7'h00;
      pf_oe_o  <= 7'h00;
    end
    else
    begin
      pf_out_o <= pf_out_nxt;
      pf_oe_o  <= pf_oe_nxt;
    end
  end

  // keyboard use only forces the enable low; the drive value stays the latch
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pg_out_o <= 3'h0;
      pg_oe_o  <= 3'h0;
    end
    else
    begin
      pg_out_o <= port_g_data_r;
      pg_oe_o  <= pg_oe_nxt;
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ph_out_o <= 2'h0;
      ph_oe_o  <= 2'h0;
    end
    else
    begin
      ph_out_o <= port_h_data_r;
      ph_oe_o  <= ph_oe_nxt;
    end
  end

endmodule

/* File: pkg/gpe_map.vh */
`ifndef GPE_MAP_VH
`define GPE_MAP_VH
`define GPE_OFS_E_DATA 12'h008
`define GPE_OFS_F_DATA 12'h009
`define GPE_OFS_G_DATA 12'h00a
`define GPE_OFS_H_DATA 12'h00b
`define GPE_IDX_E_DIR  12'h00c
`define GPE_IDX_F_DIR  12'h00d
`define GPE_IDX_G_DIR  12'h00e
`define GPE_IDX_H_DIR  12'h00f
`define GPE_W_E        8
`define GPE_W_F        7
`define GPE_W_G        3
`define GPE_W_H        2
`define GPE_W_KBI      5
`define GPE_DIR_RST    8'h00
`define GPE_DIR_RST_F  7'h00
`define GPE_DIR_RST_G  3'h0
`define GPE_DIR_RST_H  2'h0
`define GPE_HTRANS_NS  1
`endif

/* File: test/gpe_ports_properties.sv */
`timescale 1ns/10ps
module gpe_ports_props
(
  // clock and reset
  input wire        clk_i,
  input wire        rstn_i,
  // pins and overrides
  input wire [7:0]  pe_out_o,
  input wire [7:0]  pe_oe_o,
  input wire [7:0]  pe_periph_own_i,
  input wire [7:0]  pe_periph_out_i,
  input wire [7:0]  pe_periph_oe_i,
  input wire [6:0]  pf_out_o,
  input wire [6:0]  pf_oe_o,
  input wire [11:0] edge_level_select_pair_i,
  input wire [5:0]  timer_channel_out_i,
  input wire [5:0]  timer_channel_oe_i,
  input wire [2:0]  pg_oe_o,
  input wire [1:0]  ph_oe_o,
  input wire [4:0]  keyboard_irq_enable_i
);
  wire [5:0] tmr_own;
  assign tmr_own = {|edge_level_select_pair_i[11:10], |edge_level_select_pair_i[9:8],
                    |edge_level_select_pair_i[7:6], |edge_level_select_pair_i[5:4],
                    |edge_level_select_pair_i[3:2], |edge_level_select_pair_i[1:0]};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // outputs lag inputs by one edge; the edge after release still sees reset values
  sequence s_run;
    $past(rstn_i);
  endsequence
  a_rst_e_in: assert property ($rose(rstn_i) |-> pe_oe_o == 8'h00)
    else $error("port e driven after reset");
  a_rst_f_in: assert property ($rose(rstn_i) |-> pf_oe_o == 7'h00)
    else $error("port f driven after reset");
  a_rst_g_in: assert property ($rose(rstn_i) |-> pg_oe_o == 3'h0)
    else $error("port g driven after reset");
  a_rst_h_in: assert property ($rose(rstn_i) |-> ph_oe_o == 2'h0)
    else $error("port h driven after reset");
  a_kbd_g_in: assert property (s_run |-> (pg_oe_o & $past(keyboard_irq_enable_i[2:0])) == 3'h0)
    else $error("keyboard pin of port g driven");
  a_kbd_h_in: assert property (s_run |-> (ph_oe_o & $past(keyboard_irq_enable_i[4:3])) == 2'h0)
    else $error("keyboard pin of port h driven");
  a_tmr_owns_pin: assert property (s_run |-> ($past(tmr_own) & ((pf_oe_o[5:0] ^ $past(timer_channel_oe_i)) |
    (pf_out_o[5:0] ^ $past(timer_channel_out_i)))) == 6'h00) else $error("timer pin not under timer control");
  a_per_owns_pin: assert property (s_run |-> ($past(pe_periph_own_i) & ((pe_oe_o ^ $past(pe_periph_oe_i)) |
    (pe_out_o ^ $past(pe_periph_out_i)))) == 8'h00) else $error("port e pin not under peripheral control");
endmodule
bind gpe_ports gpe_ports_props u_props (.clk_i, .rstn_i, .pe_out_o, .pe_oe_o, .pe_periph_own_i, .pe_periph_out_i,
  .pe_periph_oe_i, .pf_out_o, .pf_oe_o, .edge_level_select_pair_i, .timer_channel_out_i, .timer_channel_oe_i,
  .pg_oe_o, .ph_oe_o, .keyboard_irq_enable_i);

/* File: test/gpe_pin_model.sv */
`timescale 1ns/10ps
module gpe_pin_model
(
  // pad drive from the ports
  input  wire [19:0] out_i,
  input  wire [19:0] oe_i,
  // board level where nobody drives
  input  wire [19:0] ext_i,
  // level seen at the pads
  output wire [19:0] pin_o
);
  // an undriven pad shows the board level, never the last driven value
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

/* File: test/testbench.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench;
  localparam [19:0] A = 20'ha_5c3e;
  localparam [19:0] B = 20'h3_c96a;
  reg         clk_i = 1'b0, rstn_i = 1'b0, hsel_i = 1'b1, hwrite_i = 1'b0;
  reg  [2:0]  hsize_i = 3'h2;
  reg  [1:0]  htrans_i = 2'h0;
  reg  [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, rd, msk;
  reg  [7:0]  pe_periph_own_i = 8'h00, pe_periph_out_i = 8'h00, pe_periph_oe_i = 8'h00;
  reg  [11:0] edge_level_select_pair_i = 12'h000;
  reg  [5:0]  timer_channel_out_i = 6'h00, timer_channel_oe_i = 6'h00;
  reg  [4:0]  keyboard_irq_enable_i = 5'h00;
  wire [31:0] hrdata_o;
  wire        hreadyout_o, hresp_o;
  wire        hready_i = hreadyout_o;
  wire [7:0]  pe_pin_i, pe_out_o, pe_oe_o;
  wire [6:0]  pf_pin_i, pf_out_o, pf_oe_o;
  wire [2:0]  pg_pin_i, pg_out_o, pg_oe_o;
  wire [1:0]  ph_pin_i, ph_out_o, ph_oe_o;
  wire [19:0] poe = {pe_oe_o, pf_oe_o, pg_oe_o, ph_oe_o};
  wire [19:0] pout = {pe_out_o, pf_out_o, pg_out_o, ph_out_o};
  integer     num_errors = 0, checked = 0, p, m;
  always #25 clk_i = ~clk_i;
  gpe_ports dut (.*);
  gpe_pin_model u_pins (.out_i(pout), .oe_i(poe), .ext_i(A), .pin_o({pe_pin_i, pf_pin_i, pg_pin_i, ph_pin_i}));
  function [7:0] sl(input [19:0] v, input integer n);
    case (n)
      0: sl = v[19:12];
      1: sl = {1'b0, v[11:5]};
      2: sl = {5'h00, v[4:2]};
      default: sl = {6'h00, v[1:0]};
    endcase
  endfunction
  task xfer(input [31:0] a, input w, input [31:0] d);
    begin
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
    end
  endtask
  task rdchk(input [31:0] a, input [7:0] e);
    begin
      xfer(a, 1'b0, 32'h0000_0000);
      `CHK("rdata", {24'h00_0000, e}, rd)
      `CHK("resp", 1'b0, hresp_o)
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    for (p = 0; p < 4; p++)
      rdchk(32'h30 + 4 * p, 8'h00);
    rdchk(32'h0000_0040, 8'h00);
    // latch loaded before any direction bit goes high
    for (p = 0; p < 4; p++)
      xfer(32'h20 + 4 * p, 1'b1, {24'h00_0000, sl(B, p)});
    for (m = 0; m < 3; m++)
    begin
      msk = (m == 0) ? 20'h0_0000 : (m == 1) ? 20'hf_ffff : 20'h6_9a5c;
      for (p = 0; p < 4; p++)
        xfer(32'h30 + 4 * p, 1'b1, {24'h00_0000, sl(msk, p)});
      repeat (3) @(posedge clk_i);
      for (p = 0; p < 4; p++)
        rdchk(32'h20 + 4 * p, sl((B & msk) | (A & ~msk), p));
      `CHK("oe", msk[19:0], poe)
      `CHK("out", B & msk[19:0], pout & msk[19:0])
    end
    $display("test direction done");
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    for (p = 0; p < 4; p++)
    begin
      rdchk(32'h30 + 4 * p, 8'h00);
      xfer(32'h30 + 4 * p, 1'b1, 32'h0000_00ff);
    end
    for (p = 1; p < 4; p++)
      rdchk(32'h20 + 4 * p, sl(B, p));
    $display("test reset done");
    pe_periph_oe_i <= 8'h5a;
    pe_periph_out_i <= 8'hc3;
    timer_channel_oe_i <= 6'h2d;
    timer_channel_out_i <= 6'h1b;
    for (m = 0; m < 4; m++)
    begin
      edge_level_select_pair_i <= {6{m[1:0]}};
      keyboard_irq_enable_i <= (m != 0) ? 5'h1f : 5'h00;
      pe_periph_own_i <= (m != 0) ? 8'hf0 : 8'h00;
      repeat (3) @(posedge clk_i);
      `CHK("kbd oe", (m != 0) ? 5'h00 : 5'h1f, poe[4:0])
      `CHK("tmr oe", (m != 0) ? 7'h6d : 7'h7f, poe[11:5])
      `CHK("tmr out", (m != 0) ? {B[11], 6'h1b} : B[11:5], pout[11:5])
      `CHK("per oe", (m != 0) ? 8'h5f : 8'hff, poe[19:12])
      `CHK("per out", (m != 0) ? {4'hc, B[15:12]} : B[19:12], pout[19:12])
      rdchk(32'h24, sl(B, 1));
      rdchk(32'h20, sl(B, 0));
    end
    $display("test override done");
    wrap_up;
  end
  initial
  begin
    #200000;
    num_errors++;
    wrap_up;
  end
endmodule
